/* File: mdx_regs.svh */
`ifndef MDX_REGS_SVH
`define MDX_REGS_SVH
`define MDX_A_CTRL    8'h00
`define MDX_A_STAT    8'h04
`define MDX_A_ACC     8'h08
`define MDX_A_B       8'h0c
`define MDX_A_FLAGS   8'h10
`define MDX_A_X       8'h14
`define MDX_A_Y       8'h18
`define MDX_A_DP      8'h1c
`define MDX_A_PAGE    8'h20
`define MDX_A_PC      8'h24
`define MDX_A_BANK    8'h28
`define MDX_A_IND     8'h2c
`define MDX_A_DIR     8'h30
`define MDX_A_MCFG    8'h34
`define MDX_PAGE_RST  8'h01
`define MDX_DA_ADJ    9'h006
`define MDX_DA_ADJ_HI 9'h060
`define MDX_DA_LIM    4'h9
`define MDX_ST_MUL_AB 6'h05
`define MDX_ST_MULB_B 6'h06
`define MDX_ST_MULB_S 6'h05
`define MDX_ST_MULW_B 6'h0c
`define MDX_ST_MULW_S 6'h0b
`define MDX_ST_DIV_AB 6'h0a
`define MDX_ST_DIVB_B 6'h0b
`define MDX_ST_DIVB_S 6'h0a
`define MDX_ST_DIVW_B 6'h15
`define MDX_ST_DIVW_S 6'h14
`define MDX_ST_DA     6'h01
`define MDX_ST_MOVE_HIGH_WORD_OP_B 6'h03
`define MDX_ST_MOVE_HIGH_WORD_OP_S 6'h02
`define MDX_ST_EXT_B  6'h02
`define MDX_ST_EXT_S  6'h01
`define MDX_ST_MOVE_CODE_OP   6'h06
`define MDX_ST_XRI_RB 6'h04
`define MDX_ST_XRI_RS 6'h05
`define MDX_ST_XRI_W  6'h04
`define MDX_ST_XDP_R  6'h03
`define MDX_ST_XDP_W  6'h04
`define MDX_ST_BNK_B  6'h01
`define MDX_ST_BNK_S  6'h02
`define MDX_ST_IRD_B  6'h02
`define MDX_ST_IRD_S  6'h03
`define MDX_ST_IWR_B  6'h03
`define MDX_ST_IWR_S  6'h04
`define MDX_ST_DD     6'h03
`define MDX_ST_DPI    6'h02
`define MDX_LEN_ONE   3'h1
`define MDX_LEN_TWO   3'h2
`define MDX_LEN_THREE 3'h3
`define MDX_LEN_FOUR  3'h4
`define MDX_LEN_FIVE  3'h5
`endif

/* File: mdx_pkg.sv */
package mdx_pkg;
    typedef enum logic [4:0] {
        OP_MUL_AB, OP_MUL_B, OP_MUL_W, OP_DIV_AB, OP_DIV_B, OP_DIV_W,
        OP_DA, OP_MOVE_HIGH_WORD_OP, OP_MOVE_SIGN_EXTEND_OP, OP_MOVE_ZERO_EXTEND_OP, OP_MOVE_CODE_OP_DP, OP_MOVE_CODE_OP_PC,
        OP_XRI_RD, OP_XDP_RD, OP_XRI_WR, OP_XDP_WR, OP_BANK_DIR,
        OP_IND_ACC, OP_ACC_IND, OP_DIR_DIR, OP_DP_IMM
    } mdx_op_e;
    typedef enum logic {ST_IDLE, ST_RUN} mdx_fsm_e;
    typedef enum logic [1:0] {SP_CODE, SP_DATA, SP_EXT} mdx_space_e;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mdx_bus_s;
    typedef struct packed {
        logic        rd;
        logic        wr;
        mdx_space_e  space;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } mdx_mem_s;
    typedef struct packed {
        mdx_fsm_e    fsm;
        mdx_op_e     op;
        logic [5:0]  cnt;
        logic [7:0]  acc;
        logic [7:0]  b;
        logic        cy;
        logic        ac;
        logic        ov;
        logic [31:0] x;
        logic [15:0] y;
        logic [15:0] dp;
        logic [7:0]  page;
        logic [15:0] pc;
        logic [7:0]  bank;
        logic [7:0]  ind;
        logic [15:0] dir;
        logic        ext_code;
        logic        ext_data;
        logic [3:0]  nwait;
        logic [31:0] px;
        logic [7:0]  pa;
        logic [7:0]  pb;
        logic        pcy;
        logic        pov;
        logic [2:0]  sync;
        logic        mode;
        logic [31:0] rdata;
        mdx_mem_s    mem;
        logic        done;
    } mdx_state_s;
endpackage

/* File: mdx_exec.sv */
// Notes on behaviour
// - acc times b: high byte to b, low byte to acc, 5 states
// - byte register multiply gives double-width product, 6/5 states
// - word register multiply gives 32-bit product, 12/11 states
// - acc over b: quotient to acc, remainder to b, 10 states
// - byte divide: quotient high, remainder low, 11/10 states
// - word divide: quotient high word, remainder low, 21/20 states
// - decimal adjust adds 6 to low nibble above 9 or aux carry
// - then adds 6 to high nibble above 9 or carry; 1 state
// - move high word loads bits 31:16 of dword, 3/2 states
// - sign-extending byte to word move, 2/1 states
// - zero-extending byte to word move, 2/1 states
// - code byte at acc plus pointer or pc, 6 states plus N+1 external
// - 8-bit extended read 4/5 states, 8-bit extended write 4 states
// - data pointer extended read 3 states plus N+2 external
// - data pointer extended write 4 states plus N+1 external
// - extended accesses use page byte, which resets to 01h
// - direct to bank register: 2 bytes 1 state, or 3 bytes 2 states
// - indirect to acc: 1 byte 2 states, or 2 bytes 3 states
// - acc to indirect: 3 states binary, 4 states source
// - direct to direct: 3 bytes, 3 states in both modes
// - data pointer load of 16-bit constant: 3 bytes, 2 states
`timescale 1ns/1ps
`include "mdx_regs.svh"
module mdx_exec (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             source_mode_in,
    input  wire mdx_pkg::mdx_bus_s bus_in,
    input  wire logic [7:0]       mem_rdata_in,
    output mdx_pkg::mdx_mem_s     mem_out,
    output logic [31:0]           rd_data_out,
    output logic                  busy_out,
    output logic                  done_out
);
    import mdx_pkg::*;

    mdx_state_s s;
    mdx_state_s next_s;
    logic       start;
    mdx_op_e    wop;

    function automatic logic [5:0] states_of(
        input mdx_op_e    op,
        input logic       src,
        input logic       ec,
        input logic       ed,
        input logic [3:0] n
    );
        logic [5:0] n6;
        n6 = {2'h0, n};
        case (op)
            OP_MUL_AB:   states_of = `MDX_ST_MUL_AB;
            OP_MUL_B:    states_of = src ? `MDX_ST_MULB_S
                                         : `MDX_ST_MULB_B;
            OP_MUL_W:    states_of = src ? `MDX_ST_MULW_S
                                         : `MDX_ST_MULW_B;
            OP_DIV_AB:   states_of = `MDX_ST_DIV_AB;
            OP_DIV_B:    states_of = src ? `MDX_ST_DIVB_S
                                         : `MDX_ST_DIVB_B;
            OP_DIV_W:    states_of = src ? `MDX_ST_DIVW_S
                                         : `MDX_ST_DIVW_B;
            OP_DA:       states_of = `MDX_ST_DA;
            OP_MOVE_HIGH_WORD_OP:     states_of = src ? `MDX_ST_MOVE_HIGH_WORD_OP_S
                                         : `MDX_ST_MOVE_HIGH_WORD_OP_B;
            OP_MOVE_SIGN_EXTEND_OP,
            OP_MOVE_ZERO_EXTEND_OP:     states_of = src ? `MDX_ST_EXT_S
                                         : `MDX_ST_EXT_B;
            OP_MOVE_CODE_OP_DP,
            OP_MOVE_CODE_OP_PC:  states_of = `MDX_ST_MOVE_CODE_OP
                                   + (ec ? n6 + 6'h01 : 6'h00);
            OP_XRI_RD:   states_of = src ? `MDX_ST_XRI_RS
                                         : `MDX_ST_XRI_RB;
            OP_XRI_WR:   states_of = `MDX_ST_XRI_W;
            OP_XDP_RD:   states_of = `MDX_ST_XDP_R
                                   + (ed ? n6 + 6'h02 : 6'h00);
            OP_XDP_WR:   states_of = `MDX_ST_XDP_W
                                   + (ed ? n6 + 6'h01 : 6'h00);
            OP_BANK_DIR: states_of = src ? `MDX_ST_BNK_S
                                         : `MDX_ST_BNK_B;
            OP_IND_ACC:  states_of = src ? `MDX_ST_IRD_S
                                         : `MDX_ST_IRD_B;
            OP_ACC_IND:  states_of = src ? `MDX_ST_IWR_S
                                         : `MDX_ST_IWR_B;
            OP_DIR_DIR:  states_of = `MDX_ST_DD;
            OP_DP_IMM:   states_of = `MDX_ST_DPI;
            default:     states_of = 6'h01;
        endcase
    endfunction

    function automatic logic [2:0] len_of(
        input mdx_op_e op,
        input logic    src
    );
        case (op)
            OP_MUL_B, OP_MUL_W, OP_DIV_B, OP_DIV_W, OP_MOVE_SIGN_EXTEND_OP, OP_MOVE_ZERO_EXTEND_OP:
                len_of = src ? `MDX_LEN_TWO : `MDX_LEN_THREE;
            OP_MOVE_HIGH_WORD_OP:
                len_of = src ? `MDX_LEN_FOUR : `MDX_LEN_FIVE;
            OP_BANK_DIR:
                len_of = src ? `MDX_LEN_THREE : `MDX_LEN_TWO;
            OP_IND_ACC, OP_ACC_IND:
                len_of = src ? `MDX_LEN_TWO : `MDX_LEN_ONE;
            OP_DIR_DIR, OP_DP_IMM:
                len_of = `MDX_LEN_THREE;
            default:
                len_of = `MDX_LEN_ONE;
        endcase
    endfunction

    assign wop   = mdx_op_e'(bus_in.wdata[4:0]);
    assign start = bus_in.wr && bus_in.addr == `MDX_A_CTRL
                   && s.fsm == ST_IDLE;

    always_comb begin
        logic [8:0]  da;
        logic        dcy;
        logic [15:0] q16;
        logic [15:0] r16;
        da  = {1'b0, s.acc};
        dcy = s.cy;
        q16 = 16'h0000;
        r16 = 16'h0000;
        next_s = s;
        next_s.done   = 1'b0;
        next_s.mem.rd = 1'b0;
        next_s.mem.wr = 1'b0;
        next_s.sync   = {s.sync[1:0], source_mode_in};
        // mode may only move between runs, never under one
        if (s.fsm == ST_IDLE && s.sync[2] == s.sync[1]) begin
            next_s.mode = s.sync[2];
        end
        next_s.rdata = 32'h0000_0000;
        if (bus_in.rd) begin
            case (bus_in.addr)
                `MDX_A_CTRL:  next_s.rdata = {27'h000_0000, s.op};
                `MDX_A_STAT:  next_s.rdata = {10'h000,
                    states_of(s.op, s.mode, s.ext_code, s.ext_data,
                              s.nwait),
                    5'h00, len_of(s.op, s.mode), 6'h00, s.mode,
                    s.fsm == ST_RUN};
                `MDX_A_ACC:   next_s.rdata = {24'h00_0000, s.acc};
                `MDX_A_B:     next_s.rdata = {24'h00_0000, s.b};
                `MDX_A_FLAGS: next_s.rdata = {29'h0000_0000,
                                              s.ov, s.ac, s.cy};
                `MDX_A_X:     next_s.rdata = s.x;
                `MDX_A_Y:     next_s.rdata = {16'h0000, s.y};
                `MDX_A_DP:    next_s.rdata = {16'h0000, s.dp};
                `MDX_A_PAGE:  next_s.rdata = {24'h00_0000, s.page};
                `MDX_A_PC:    next_s.rdata = {16'h0000, s.pc};
                `MDX_A_BANK:  next_s.rdata = {24'h00_0000, s.bank};
                `MDX_A_IND:   next_s.rdata = {24'h00_0000, s.ind};
                `MDX_A_DIR:   next_s.rdata = {16'h0000, s.dir};
                `MDX_A_MCFG:  next_s.rdata = {24'h00_0000, s.nwait,
                                              2'h0, s.ext_data, s.ext_code};
                default:      next_s.rdata = 32'h0000_0000;
            endcase
        end
        // operand writes are dropped while a run is under way
        if (bus_in.wr && s.fsm == ST_IDLE) begin
            case (bus_in.addr)
                `MDX_A_ACC:   next_s.acc = bus_in.wdata[7:0];
                `MDX_A_B:     next_s.b = bus_in.wdata[7:0];
                `MDX_A_FLAGS: {next_s.ov, next_s.ac, next_s.cy} =
                                  bus_in.wdata[2:0];
                `MDX_A_X:     next_s.x = bus_in.wdata;
                `MDX_A_Y:     next_s.y = bus_in.wdata[15:0];
                `MDX_A_DP:    next_s.dp = bus_in.wdata[15:0];
                `MDX_A_PAGE:  next_s.page = bus_in.wdata[7:0];
                `MDX_A_PC:    next_s.pc = bus_in.wdata[15:0];
                `MDX_A_BANK:  next_s.bank = bus_in.wdata[7:0];
                `MDX_A_IND:   next_s.ind = bus_in.wdata[7:0];
                `MDX_A_DIR:   next_s.dir = bus_in.wdata[15:0];
                `MDX_A_MCFG: begin
                    next_s.ext_code = bus_in.wdata[0];
                    next_s.ext_data = bus_in.wdata[1];
                    next_s.nwait    = bus_in.wdata[7:4];
                end
                default: ;
            endcase
        end
        case (s.fsm)
            ST_IDLE: begin
                if (start) begin
                    next_s.fsm = ST_RUN;
                    next_s.op  = wop;
                    next_s.cnt = states_of(wop, s.mode, s.ext_code,
                                           s.ext_data, s.nwait);
                    next_s.px  = s.x;
                    next_s.pa  = s.acc;
                    next_s.pb  = s.b;
                    next_s.pcy = s.cy;
                    next_s.pov = s.ov;
                    case (wop)
                        OP_MUL_AB: begin
                            {next_s.pb, next_s.pa} = s.acc * s.b;
                            next_s.pcy = 1'b0;
                            next_s.pov = s.b != 8'h00 && s.acc * s.b > 255;
                        end
                        OP_MUL_B: begin
                            next_s.px[15:0] = s.x[7:0] * s.y[7:0];
                            next_s.pcy = 1'b0;
                        end
                        OP_MUL_W: begin
                            next_s.px = s.x[15:0] * s.y;
                            next_s.pcy = 1'b0;
                        end
                        // divide by zero flags overflow, targets keep
                        OP_DIV_AB: begin
                            next_s.pcy = 1'b0;
                            next_s.pov = s.b == 8'h00;
                            if (s.b != 8'h00) begin
                                next_s.pa = s.acc / s.b;
                                next_s.pb = s.acc % s.b;
                            end
                        end
                        OP_DIV_B: begin
                            next_s.pcy = 1'b0;
                            next_s.pov = s.y[7:0] == 8'h00;
                            if (s.y[7:0] != 8'h00) begin
                                next_s.px[15:8] = s.x[7:0] / s.y[7:0];
                                next_s.px[7:0]  = s.x[7:0] % s.y[7:0];
                            end
                        end
                        OP_DIV_W: begin
                            next_s.pcy = 1'b0;
                            next_s.pov = s.y == 16'h0000;
                            if (s.y != 16'h0000) begin
                                q16 = s.x[15:0] / s.y;
                                r16 = s.x[15:0] % s.y;
                                next_s.px = {q16, r16};
                            end
                        end
                        OP_DA: begin
                            if (s.acc[3:0] > `MDX_DA_LIM || s.ac) begin
                                da  = da + `MDX_DA_ADJ;
                                dcy = dcy | da[8];
                            end
                            if (da[7:4] > `MDX_DA_LIM || dcy) begin
                                da  = {1'b0, da[7:0]} + `MDX_DA_ADJ_HI;
                                dcy = dcy | da[8];
                            end
                            next_s.pa  = da[7:0];
                            next_s.pcy = dcy;
                        end
                        OP_MOVE_HIGH_WORD_OP:
                            next_s.px[31:16] = s.y;
                        OP_MOVE_SIGN_EXTEND_OP:
                            next_s.px[15:0] = {{8{s.y[7]}}, s.y[7:0]};
                        OP_MOVE_ZERO_EXTEND_OP:
                            next_s.px[15:0] = {8'h00, s.y[7:0]};
                        OP_MOVE_CODE_OP_DP, OP_MOVE_CODE_OP_PC: begin
                            next_s.mem.rd    = 1'b1;
                            next_s.mem.space = SP_CODE;
                            next_s.mem.addr  = {8'h00, {8'h00, s.acc}
                                + (wop == OP_MOVE_CODE_OP_DP ? s.dp : s.pc)};
                        end
                        OP_XRI_RD, OP_XRI_WR: begin
                            next_s.mem.rd    = wop == OP_XRI_RD;
                            next_s.mem.wr    = wop == OP_XRI_WR;
                            next_s.mem.space = SP_EXT;
                            next_s.mem.addr  = {s.page, 8'h00, s.ind};
                            next_s.mem.wdata = s.acc;
                        end
                        OP_XDP_RD, OP_XDP_WR: begin
                            next_s.mem.rd    = wop == OP_XDP_RD;
                            next_s.mem.wr    = wop == OP_XDP_WR;
                            next_s.mem.space = SP_EXT;
                            next_s.mem.addr  = {s.page, s.dp};
                            next_s.mem.wdata = s.acc;
                        end
                        OP_BANK_DIR, OP_DIR_DIR: begin
                            next_s.mem.rd    = 1'b1;
                            next_s.mem.space = SP_DATA;
                            next_s.mem.addr  = {16'h0000, s.dir[7:0]};
                        end
                        OP_IND_ACC, OP_ACC_IND: begin
                            next_s.mem.rd    = wop == OP_IND_ACC;
                            next_s.mem.wr    = wop == OP_ACC_IND;
                            next_s.mem.space = SP_DATA;
                            next_s.mem.addr  = {16'h0000, s.ind};
                            next_s.mem.wdata = s.acc;
                        end
                        default: ;
                    endcase
                end
            end
            ST_RUN: begin
                next_s.cnt = s.cnt - 6'h01;
                if (s.cnt == 6'h01) begin
                    next_s.fsm  = ST_IDLE;
                    next_s.done = 1'b1;
                    next_s.x    = s.px;
                    next_s.acc  = s.pa;
                    next_s.b    = s.pb;
                    next_s.cy   = s.pcy;
                    next_s.ov   = s.pov;
                    // read data must stand in the last state of the run
                    case (s.op)
                        OP_MOVE_CODE_OP_DP, OP_MOVE_CODE_OP_PC, OP_XRI_RD, OP_XDP_RD,
                        OP_IND_ACC:
                            next_s.acc = mem_rdata_in;
                        OP_BANK_DIR:
                            next_s.bank = mem_rdata_in;
                        OP_DIR_DIR: begin
                            next_s.mem.wr    = 1'b1;
                            next_s.mem.space = SP_DATA;
                            next_s.mem.addr  = {16'h0000, s.dir[15:8]};
                            next_s.mem.wdata = mem_rdata_in;
                        end
                        OP_DP_IMM:
                            next_s.dp = s.y;
                        default: ;
                    endcase
                end
            end
            default: next_s.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s      <= '0;
            s.page <= `MDX_PAGE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign mem_out     = s.mem;
    assign rd_data_out = s.rdata;
    assign busy_out    = s.fsm == ST_RUN;
    assign done_out    = s.done;

    property p_mul_ab;
        @(posedge clk_in) disable iff (rst_in)
        (start && wop == OP_MUL_AB) |=> busy_out [*5] ##1 !busy_out;
    endproperty
    a_mul_ab: assert property (p_mul_ab)
        else $error("acc by b multiply not 5 states");

    property p_mul_w_bin;
        @(posedge clk_in) disable iff (rst_in)
        (start && wop == OP_MUL_W && !s.mode)
            |-> ##12 busy_out ##1 (!busy_out && done_out);
    endproperty
    a_mul_w_bin: assert property (p_mul_w_bin)
        else $error("word multiply not 12 states in binary mode");

    property p_div_ab;
        @(posedge clk_in) disable iff (rst_in)
        (start && wop == OP_DIV_AB && s.b != 8'h00)
            |-> ##11 (s.acc == $past(s.acc, 11) / $past(s.b, 11));
    endproperty
    a_div_ab: assert property (p_div_ab)
        else $error("acc by b quotient wrong or late");

    property p_da_valid;
        @(posedge clk_in) disable iff (rst_in)
        (start && wop == OP_DA && !s.cy && !s.ac
            && s.acc[7:4] <= `MDX_DA_LIM && s.acc[3:0] <= `MDX_DA_LIM)
            |-> ##1 busy_out ##1 (!busy_out && $stable(s.acc));
    endproperty
    a_da_valid: assert property (p_da_valid)
        else $error("decimal adjust changed a valid bcd byte");

    property p_move_high_word_op;
        @(posedge clk_in) disable iff (rst_in)
        (done_out && s.op == OP_MOVE_HIGH_WORD_OP) |-> s.x[31:16] == s.y;
    endproperty
    a_move_high_word_op: assert property (p_move_high_word_op)
        else $error("high word move result wrong");

    property p_move_sign_extend_op;
        @(posedge clk_in) disable iff (rst_in)
        (done_out && s.op == OP_MOVE_SIGN_EXTEND_OP)
            |-> s.x[15:0] == {{8{s.y[7]}}, s.y[7:0]};
    endproperty
    a_move_sign_extend_op: assert property (p_move_sign_extend_op)
        else $error("sign extension wrong");

    property p_move_code_op_addr;
        @(posedge clk_in) disable iff (rst_in)
        (start && wop == OP_MOVE_CODE_OP_DP) |=> (mem_out.rd
            && mem_out.space == SP_CODE
            && mem_out.addr[15:0] == 16'($past(s.acc)) + $past(s.dp));
    endproperty
    a_move_code_op_addr: assert property (p_move_code_op_addr)
        else $error("code fetch address wrong");

    property p_ext_page;
        @(posedge clk_in) disable iff (rst_in)
        ((mem_out.rd || mem_out.wr) && mem_out.space == SP_EXT)
            |-> mem_out.addr[23:16] == s.page;
    endproperty
    a_ext_page: assert property (p_ext_page)
        else $error("extended access outside page");

    property p_xdp_rd_int;
        @(posedge clk_in) disable iff (rst_in)
        (start && wop == OP_XDP_RD && !s.ext_data)
            |-> ##3 busy_out ##1 !busy_out;
    endproperty
    a_xdp_rd_int: assert property (p_xdp_rd_int)
        else $error("on-chip pointer read not 3 states");

    property p_mode_hold;
        @(posedge clk_in) disable iff (rst_in)
        busy_out |=> $stable(s.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("encoding mode moved during a run");

    property p_dp_imm;
        @(posedge clk_in) disable iff (rst_in)
        (start && wop == OP_DP_IMM) |-> ##3 (s.dp == $past(s.y, 3));
    endproperty
    a_dp_imm: assert property (p_dp_imm)
        else $error("pointer load wrong or not 2 states");
endmodule

/* File: mdx_mem_model.sv */
`timescale 1ns/1ps
module mdx_mem_model (
    input  wire logic              clk_in,
    input  wire mdx_pkg::mdx_mem_s mem_in,
    output logic [7:0]             rdata_out
);
    import mdx_pkg::*;
    logic [7:0] store [256];
    // seeded so every location reads a distinct pattern, zero only at 5Ah
    initial for (int i = 0; i < 256; i++) store[i] = 8'(i) ^ 8'h5a;
    always @(posedge clk_in)
        if (mem_in.wr) store[mem_in.addr[7:0]] <= mem_in.wdata;
    assign rdata_out = store[mem_in.addr[7:0]];
endmodule

/* File: mul_div_bcd_move_exec_test.sv */
`timescale 1ns/1ps
`include "mdx_regs.svh"
module mul_div_bcd_move_exec_test;
    import mdx_pkg::*;
    logic clk_in = 0, rst_in = 1, source_mode_in = 0;
    mdx_bus_s bus_in = '0;
    logic [7:0] mem_rdata_in;
    mdx_mem_s mem_out;
    logic [31:0] rd_data_out, got;
    logic busy_out, done_out;
    int err_count = 0, tests_run = 0;
    always #20 clk_in = ~clk_in;
    mdx_exec mdx_exec_i (.clk_in(clk_in), .rst_in(rst_in),
        .source_mode_in(source_mode_in), .bus_in(bus_in),
        .mem_rdata_in(mem_rdata_in), .mem_out(mem_out),
        .rd_data_out(rd_data_out), .busy_out(busy_out), .done_out(done_out));
    mdx_mem_model mdx_mem_model_i (.clk_in(clk_in), .mem_in(mem_out),
        .rdata_out(mem_rdata_in));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in) bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in) bus_in.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in) bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge clk_in) bus_in.rd <= 1'b0;
        #1 d = rd_data_out;
    endtask
    // counts busy cycles of one run, bounded so a hang cannot stall the run
    task automatic run(input mdx_op_e op, input int n);
        int cnt = 0;
        wr(`MDX_A_CTRL, 32'(op));
        #1;
        while (busy_out === 1'b1 && cnt < 40) begin
            cnt++;
            @(posedge clk_in) #1;
        end
        chk(32'(cnt), 32'(n));
        chk(32'(done_out), 32'h0000_0001);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, got);
        chk(got, e);
    endtask
    task automatic print_verdict;
        $display("errors %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic binary_ops;
        rchk(`MDX_A_PAGE, 32'h0000_0001);
        wr(`MDX_A_ACC, 32'h0000_00c8);
        wr(`MDX_A_B, 32'h0000_0003);
        run(OP_MUL_AB, 5);
        rchk(`MDX_A_ACC, 32'h0000_0058);
        rchk(`MDX_A_B, 32'h0000_0002);
        wr(`MDX_A_ACC, 32'h0000_0064);
        wr(`MDX_A_B, 32'h0000_0007);
        run(OP_DIV_AB, 10);
        rchk(`MDX_A_ACC, 32'h0000_000e);
        rchk(`MDX_A_B, 32'h0000_0002);
        wr(`MDX_A_X, 32'h0000_1234);
        wr(`MDX_A_Y, 32'h0000_0010);
        run(OP_DIV_W, 21);
        rchk(`MDX_A_X, 32'h0123_0004);
        wr(`MDX_A_Y, 32'h0000_beef);
        run(OP_MOVE_HIGH_WORD_OP, 3);
        rchk(`MDX_A_X, 32'hbeef_0004);
        wr(`MDX_A_FLAGS, 32'h0000_0000);
        wr(`MDX_A_ACC, 32'h0000_009b);
        run(OP_DA, 1);
        rchk(`MDX_A_ACC, 32'h0000_0001);
        rchk(`MDX_A_FLAGS, 32'h0000_0001);
        wr(`MDX_A_Y, 32'h0000_0034);
        run(OP_DP_IMM, 2);
        run(OP_XDP_RD, 3);
        chk(32'(mem_out.addr), 32'h0001_0034);
        rchk(`MDX_A_ACC, 32'h0000_006e);
    endtask
    task automatic byte_ops;
        wr(`MDX_A_X, 32'h0000_0012);
        wr(`MDX_A_Y, 32'h0000_0005);
        run(OP_MUL_B, 6);
        rchk(`MDX_A_X, 32'h0000_005a);
        run(OP_DIV_B, 11);
        rchk(`MDX_A_X, 32'h0000_1200);
        wr(`MDX_A_X, 32'h0000_0100);
        wr(`MDX_A_Y, 32'h0000_0300);
        run(OP_MUL_W, 12);
        rchk(`MDX_A_X, 32'h0003_0000);
        wr(`MDX_A_FLAGS, 32'h0000_0000);
        wr(`MDX_A_ACC, 32'h0000_0045);
        run(OP_DA, 1);
        rchk(`MDX_A_ACC, 32'h0000_0045);
        wr(`MDX_A_Y, 32'h0000_0085);
        run(OP_MOVE_SIGN_EXTEND_OP, 2);
        rchk(`MDX_A_X, 32'h0003_ff85);
        run(OP_MOVE_ZERO_EXTEND_OP, 2);
        rchk(`MDX_A_X, 32'h0003_0085);
    endtask
    task automatic move_ops;
        wr(`MDX_A_ACC, 32'h0000_0010);
        wr(`MDX_A_DP, 32'h0000_0020);
        run(OP_MOVE_CODE_OP_DP, 6);
        chk(32'(mem_out.addr), 32'h0000_0030);
        rchk(`MDX_A_ACC, 32'h0000_006a);
        wr(`MDX_A_MCFG, 32'h0000_0021);
        wr(`MDX_A_PC, 32'h0000_0005);
        run(OP_MOVE_CODE_OP_PC, 9);
        rchk(`MDX_A_ACC, 32'h0000_0035);
        wr(`MDX_A_MCFG, 32'h0000_0022);
        run(OP_XDP_WR, 7);
        wr(`MDX_A_ACC, 32'h0000_0000);
        run(OP_XDP_RD, 7);
        rchk(`MDX_A_ACC, 32'h0000_0035);
        wr(`MDX_A_MCFG, 32'h0000_0000);
        wr(`MDX_A_IND, 32'h0000_0040);
        run(OP_XRI_RD, 4);
        rchk(`MDX_A_ACC, 32'h0000_001a);
        wr(`MDX_A_IND, 32'h0000_0041);
        run(OP_XRI_WR, 4);
        wr(`MDX_A_ACC, 32'h0000_0000);
        run(OP_IND_ACC, 2);
        rchk(`MDX_A_ACC, 32'h0000_001a);
        wr(`MDX_A_ACC, 32'h0000_0077);
        wr(`MDX_A_IND, 32'h0000_0042);
        run(OP_ACC_IND, 3);
        wr(`MDX_A_DIR, 32'h0000_5042);
        run(OP_DIR_DIR, 3);
        wr(`MDX_A_DIR, 32'h0000_0050);
        run(OP_BANK_DIR, 1);
        rchk(`MDX_A_BANK, 32'h0000_0077);
    endtask
    task automatic source_ops;
        @(posedge clk_in) source_mode_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        wr(`MDX_A_X, 32'h0000_0200);
        wr(`MDX_A_Y, 32'h0000_0300);
        run(OP_MUL_W, 11);
        rchk(`MDX_A_X, 32'h0006_0000);
        rchk(`MDX_A_STAT, 32'h000b_0202);
        wr(`MDX_A_X, 32'h0000_0700);
        run(OP_DIV_W, 20);
        rchk(`MDX_A_X, 32'h0002_0100);
        wr(`MDX_A_ACC, 32'h0000_0000);
        run(OP_XRI_RD, 5);
        rchk(`MDX_A_ACC, 32'h0000_0077);
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        binary_ops();
        byte_ops();
        move_ops();
        source_ops();
        print_verdict();
    end
endmodule
